// ===== shared/drc_consts.svh
// Register offsets, field positions, reset values and codes for the receiver configuration bank.
// Assumes an 8-bit register port with byte offsets.
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH

`define DRC_ADDR_MODE        8'h10
`define DRC_ADDR_EQ          8'h11
`define DRC_ADDR_BAND        8'h12

`define DRC_MODE_RESET       8'h3E
`define DRC_EQ_RESET         8'h00
`define DRC_BAND_RESET       8'h00

`define DRC_POS_SPLIT        7
`define DRC_POS_CHMODE       5
`define DRC_POS_LANES_A      3
`define DRC_POS_LANES_B      1
`define DRC_POS_STRICT       0
`define DRC_POS_DEQ_A        6
`define DRC_POS_DEQ_B        4
`define DRC_POS_CEQ_A        2
`define DRC_POS_CEQ_B        0

`define DRC_BAND_MIN         8'h08
`define DRC_BAND_MAX         8'h64

`endif

// ===== shared/drc_pkg.sv
// Types shared by the receiver configuration bank and its decoder.
// Assumes drc_consts.svh holds the numeric values.
package drc_pkg;

    typedef enum logic [1:0] {
        DRC_CH_DUAL,
        DRC_CH_SINGLE,
        DRC_CH_TWO_SINGLE,
        DRC_CH_RESERVED
    } drc_chmode_e;

    typedef enum logic [1:0] {
        DRC_EQ_NONE,
        DRC_EQ_1DB,
        DRC_EQ_RESERVED,
        DRC_EQ_2DB
    } drc_eq_e;

    typedef struct packed {
        logic [2:0] lanes_a;
        logic [2:0] lanes_b;
        logic [1:0] eq_db_data_a;
        logic [1:0] eq_db_data_b;
        logic [1:0] eq_db_clk_a;
        logic [1:0] eq_db_clk_b;
    } drc_front_s;

    typedef struct packed {
        logic dual;
        logic single;
        logic two_single;
        logic left_right;
        logic strict_start_leader;
        logic band_valid;
        logic code_reserved;
    } drc_mode_s;

endpackage

// ===== design/drc_decode.sv
// Combinational decode of the stored configuration fields into front-end controls.
// Assumes the caller registers the outputs.
`timescale 1ns/10ps
`include "drc_consts.svh"

module drc_decode
(
    input  wire logic [7:0]          mode_reg,
    input  wire logic [7:0]          eq_reg,
    input  wire logic [7:0]          band_reg,
    output drc_pkg::drc_front_s      front,
    output drc_pkg::drc_mode_s       mode
);

    logic [1:0] eq_code [4];
    logic [1:0] eq_db   [4];

    assign eq_code[0] = eq_reg[`DRC_POS_DEQ_A +: 2];
    assign eq_code[1] = eq_reg[`DRC_POS_DEQ_B +: 2];
    assign eq_code[2] = eq_reg[`DRC_POS_CEQ_A +: 2];
    assign eq_code[3] = eq_reg[`DRC_POS_CEQ_B +: 2];

    // Reserved code drives no equalization so the front end stays safe
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_eq
            always_comb
            begin
                case (drc_pkg::drc_eq_e'(eq_code[gi]))
                    drc_pkg::DRC_EQ_1DB: eq_db[gi] = 2'h1;  // R06 R07 R08
                    drc_pkg::DRC_EQ_2DB: eq_db[gi] = 2'h2;  // R06 R07 R08
                    default:             eq_db[gi] = 2'h0;
                endcase
            end
        end
    endgenerate

    function automatic logic [2:0] lanes(input logic [1:0] code);
        lanes = 3'h4 - {1'b0, code};
    endfunction

    logic [1:0] chm;
    logic       rsv;
    assign chm = mode_reg[`DRC_POS_CHMODE +: 2];
    assign rsv = (chm == 2'h3) || (eq_code[0] == 2'h2) || (eq_code[1] == 2'h2)
               || (eq_code[2] == 2'h2) || (eq_code[3] == 2'h2);

    always_comb
    begin
        front.lanes_a      = lanes(mode_reg[`DRC_POS_LANES_A +: 2]);  // R03
        front.lanes_b      = lanes(mode_reg[`DRC_POS_LANES_B +: 2]);  // R04
        front.eq_db_data_a = eq_db[0];
        front.eq_db_data_b = eq_db[1];
        front.eq_db_clk_a  = eq_db[2];
        front.eq_db_clk_b  = eq_db[3];
        mode.dual          = (chm == 2'h0);  // R02
        mode.single        = (chm == 2'h1);  // R02
        mode.two_single    = (chm == 2'h2);  // R02
        // Pixel split only means something in dual-channel reception
        mode.left_right    = mode_reg[`DRC_POS_SPLIT] && (chm == 2'h0);  // R01
        mode.strict_start_leader = mode_reg[`DRC_POS_STRICT];  // R05
        mode.band_valid    = (band_reg >= `DRC_BAND_MIN) && (band_reg <= `DRC_BAND_MAX);  // R09
        mode.code_reserved = rsv;  // R10
    end

endmodule // drc_decode

// ===== design/drc_regs.sv
// Receiver configuration register bank with front-end control outputs and leader check.
// Assumes a single-cycle register port master and a synchronous 8-bit leader sample.
`timescale 1ns/10ps
`include "drc_consts.svh"

//Function
// (R01) The split bit picks odd/even at 0 and left/right at 1 for dual reception, reset 0.
// (R02) The channel field selects dual at 00, single at 01 (reset), two singles at 10.
// (R03) Channel A lane field enables four, three, two or one lane for 00..11, reset 11.
// (R04) Channel B lane field enables four, three, two or one lane for 00..11, reset 11.
// (R05) With strict clear a leader with one bit error is accepted; with strict set none.
// (R06) Channel A data equalizer gives 0, 1 or 2 dB for 00, 01, 11, reset 00.
// (R07) Channel B data equalizer gives 0, 1 or 2 dB for 00, 01, 11, reset 00.
// (R08) The two clock equalizer fields give 0, 1 or 2 dB for 00, 01, 11, reset 00.
// (R09) The channel A band field counts 5 MHz steps from 0x08 to 0x64, others reserved.
// (R10) Software keeps reserved codes out of the mode, equalizer and band fields.
// (R11) Every field reads back the last written value or its reset value.
module drc_regs
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire logic                leader_valid,
    input  wire logic [7:0]          leader_byte,
    output logic                     leader_ok,
    output logic                     leader_reject,
    output drc_pkg::drc_front_s      front_cfg,
    output drc_pkg::drc_mode_s       mode_cfg,
    output logic      [7:0]          chan_a_clock_band
);

    // Expected leader byte of a start of transmission
    localparam logic [7:0] LEADER = 8'hB8;

    logic [7:0] mode_q, mode_d;
    logic [7:0] eq_q, eq_d;
    logic [7:0] band_q, band_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        mode_d  = mode_q;
        eq_d    = eq_q;
        band_d  = band_q;
        rdata_d = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                `DRC_ADDR_MODE: mode_d = reg_wdata;  // R11
                `DRC_ADDR_EQ:   eq_d   = reg_wdata;  // R11
                `DRC_ADDR_BAND: band_d = reg_wdata;  // R11
                default:        mode_d = mode_q;
            endcase
        end
        // Unmapped addresses read as zero
        if (reg_rd)
        begin
            case (reg_addr)
                `DRC_ADDR_MODE: rdata_d = mode_q;  // R11
                `DRC_ADDR_EQ:   rdata_d = eq_q;  // R11
                `DRC_ADDR_BAND: rdata_d = band_q;  // R11
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q  <= `DRC_MODE_RESET;  // R01 R02 R03 R04
            eq_q    <= `DRC_EQ_RESET;  // R06 R07 R08
            band_q  <= `DRC_BAND_RESET;
            rdata_q <= 8'h00;
        end
        else
        begin
            mode_q  <= mode_d;
            eq_q    <= eq_d;
            band_q  <= band_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    drc_pkg::drc_front_s front_w;
    drc_pkg::drc_mode_s  mode_w;

    drc_decode u_decode
    (
        .mode_reg (mode_q),
        .eq_reg   (eq_q),
        .band_reg (band_q),
        .front    (front_w),
        .mode     (mode_w)
    );

    // Leader check: count mismatched bits against the expected pattern
    logic [7:0] diff;
    logic [3:0] nerr;
    logic       ok_d, rej_d, ok_q, rej_q;
    drc_pkg::drc_front_s front_q;
    drc_pkg::drc_mode_s  modecfg_q;
    logic [7:0] bandout_q;

    always_comb
    begin
        diff = leader_byte ^ LEADER;
        nerr = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            nerr = nerr + {3'h0, diff[i]};
        end
        ok_d  = 1'b0;
        rej_d = 1'b0;
        if (leader_valid)
        begin
            // Strict mode accepts only an exact leader
            if ((nerr == 4'h0) || ((nerr == 4'h1) && !mode_q[`DRC_POS_STRICT]))  // R05
            begin
                ok_d = 1'b1;
            end
            else
            begin
                rej_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ok_q      <= 1'b0;
            rej_q     <= 1'b0;
            front_q   <= '0;
            modecfg_q <= '0;
            bandout_q <= 8'h00;
        end
        else
        begin
            ok_q      <= ok_d;
            rej_q     <= rej_d;
            front_q   <= front_w;  // R03 R04 R06 R07 R08
            modecfg_q <= mode_w;  // R01 R02
            bandout_q <= band_q;  // R09
        end
    end

    assign leader_ok         = ok_q;
    assign leader_reject     = rej_q;
    assign front_cfg         = front_q;
    assign mode_cfg          = modecfg_q;
    assign chan_a_clock_band = bandout_q;

    property p_readback;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && !reg_wr && reg_addr == `DRC_ADDR_MODE) |=> (reg_rdata == $past(mode_q));
    endproperty
    a_readback: assert property (p_readback) else $error("mode readback wrong"); // R11

    property p_write_eq;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == `DRC_ADDR_EQ) |=> (eq_q == $past(reg_wdata));
    endproperty
    a_write_eq: assert property (p_write_eq) else $error("eq write lost"); // R11

    // Sampled rst keeps the release edge out: the outputs still carry their reset zeros then
    property p_lanes_a;
        @(posedge clk_sys) disable iff (rst)
        (!rst && mode_q[4:3] == 2'h3) |=> (front_cfg.lanes_a == 3'h1);
    endproperty
    a_lanes_a: assert property (p_lanes_a) else $error("lane a decode wrong"); // R03

    property p_lanes_b;
        @(posedge clk_sys) disable iff (rst)
        (mode_q[2:1] == 2'h0) |=> (front_cfg.lanes_b == 3'h4);
    endproperty
    a_lanes_b: assert property (p_lanes_b) else $error("lane b decode wrong"); // R04

    property p_tolerant;
        @(posedge clk_sys) disable iff (rst)
        (leader_valid && !mode_q[0] && $countones(leader_byte ^ LEADER) == 1) |=> leader_ok;
    endproperty
    a_tolerant: assert property (p_tolerant) else $error("single error rejected"); // R05

    property p_strict;
        @(posedge clk_sys) disable iff (rst)
        (leader_valid && mode_q[0] && leader_byte != LEADER) |=> (leader_reject && !leader_ok);
    endproperty
    a_strict: assert property (p_strict) else $error("strict leader accepted"); // R05

    property p_dual;
        @(posedge clk_sys) disable iff (rst)
        (mode_q[6:5] == 2'h0) |=> (mode_cfg.dual && mode_cfg.left_right == $past(mode_q[7]));
    endproperty
    a_dual: assert property (p_dual) else $error("dual split wrong"); // R01

    property p_single;
        @(posedge clk_sys) disable iff (rst)
        (!rst && mode_q[6:5] == 2'h1) |=> (mode_cfg.single && !mode_cfg.dual);
    endproperty
    a_single: assert property (p_single) else $error("single mode wrong"); // R02

    property p_eq2;
        @(posedge clk_sys) disable iff (rst)
        (eq_q[7:6] == 2'h3 && eq_q[1:0] == 2'h1) |=>
        (front_cfg.eq_db_data_a == 2'h2 && front_cfg.eq_db_clk_b == 2'h1);
    endproperty
    a_eq2: assert property (p_eq2) else $error("equalizer decode wrong"); // R06

    property p_band;
        @(posedge clk_sys) disable iff (rst)
        (band_q < `DRC_BAND_MIN || band_q > `DRC_BAND_MAX) |=> !mode_cfg.band_valid;
    endproperty
    a_band: assert property (p_band) else $error("band range wrong"); // R09

endmodule // drc_regs

// ===== tb/drc_leader_src.sv
// Partner model: processor side of the link, sending start leader bytes.
// Assumes the bench raises send for one cycle, changed right after a rising edge.
`timescale 1ns/10ps
module drc_leader_src
#(
    parameter logic [7:0] LEADER = 8'hb8
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       send,
    input  wire logic [7:0] flip_mask,
    output logic            leader_valid,
    output logic [7:0]      leader_byte
);
    // Between leaders the byte toggles, so the cycle after a leader carries its complement
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            leader_valid <= 1'b0;
            leader_byte  <= 8'h00;
        end
        else
        begin
            leader_valid <= send;
            leader_byte  <= send ? (LEADER ^ flip_mask) : ~leader_byte;
        end
    end
endmodule // drc_leader_src

// ===== tb/test_dsi_receiver_config_regs.sv
// Testbench for the receiver configuration bank: register port, decoded controls, leader check.
// Assumes drc_pkg is compiled first and drc_consts.svh is on the include path.
`timescale 1ns/10ps
`include "drc_consts.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_dsi_receiver_config_regs;
    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          reg_addr = 8'h00;
    logic [7:0]          reg_wdata = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [7:0]          reg_rdata;
    logic                send = 1'b0;
    logic [7:0]          flip_mask = 8'h00;
    logic                leader_valid;
    logic [7:0]          leader_byte;
    logic                leader_ok;
    logic                leader_reject;
    drc_pkg::drc_front_s front_cfg;
    drc_pkg::drc_mode_s  mode_cfg;
    logic [7:0]          chan_a_clock_band;
    int                  compares = 0;
    int                  miscompares = 0;
    int                  shadow [3];
    logic [7:0]          i_masks [4] = '{8'h00, 8'h01, 8'h80, 8'h03};

    always #20 clk_sys = ~clk_sys;

    drc_regs i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .leader_valid(leader_valid), .leader_byte(leader_byte), .leader_ok(leader_ok),
        .leader_reject(leader_reject), .front_cfg(front_cfg), .mode_cfg(mode_cfg),
        .chan_a_clock_band(chan_a_clock_band));
    drc_leader_src i_src (.clk_sys(clk_sys), .rst(rst), .send(send),
        .flip_mask(flip_mask), .leader_valid(leader_valid), .leader_byte(leader_byte));

    function automatic logic [1:0] eqdb(input logic [1:0] c);
        return (c == 2'b11) ? 2'd2 : c;
    endfunction

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        if (a >= 8'h10 && a <= 8'h12)
            shadow[a - 8'h10] = d;
    endtask

    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h10 && a <= 8'h12) ? 8'(shadow[a - 8'h10]) : 8'h00;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    task automatic cfg_chk();
        drc_pkg::drc_front_s f;
        drc_pkg::drc_mode_s  m;
        logic [1:0]          ch;
        ch = shadow[0][6:5];
        f.lanes_a = 3'd4 - 3'(shadow[0][4:3]);
        f.lanes_b = 3'd4 - 3'(shadow[0][2:1]);
        f.eq_db_data_a = eqdb(shadow[1][7:6]);
        f.eq_db_data_b = eqdb(shadow[1][5:4]);
        f.eq_db_clk_a = eqdb(shadow[1][3:2]);
        f.eq_db_clk_b = eqdb(shadow[1][1:0]);
        m.dual = (ch == 2'b00);
        m.single = (ch == 2'b01);
        m.two_single = (ch == 2'b10);
        m.left_right = m.dual & shadow[0][7];
        m.strict_start_leader = shadow[0][0];
        m.band_valid = (shadow[2] >= 8'h08) && (shadow[2] <= 8'h64);
        m.code_reserved = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("front_cfg", f, front_cfg)
        `CHK("mode_cfg", m, mode_cfg)
        `CHK("chan_a_clock_band", 8'(shadow[2]), chan_a_clock_band)
    endtask

    task automatic leader_chk(input logic [7:0] mask);
        logic ok;
        ok = shadow[0][0] ? (mask == 8'h00) : ($countones(mask) <= 1);
        @(posedge clk_sys);
        send      <= 1'b1;
        flip_mask <= mask;
        @(posedge clk_sys);
        send      <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("leader_ok", ok, leader_ok)
        `CHK("leader_reject", !ok, leader_reject)
    endtask

    initial
    begin
        logic [7:0] md;
        logic [7:0] eq;
        logic [7:0] bd;
        shadow = '{8'h3e, 8'h00, 8'h00};
        void'($urandom(32'h390e_f7b7));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        cfg_chk();
        for (int a = 8'h0f; a <= 8'h13; a++)
            rd_chk(8'(a));
        wr(8'h13, 8'hff);
        rd_chk(8'h13);
        foreach (shadow[k])
            rd_chk(8'(8'h10 + k));
        foreach (i_masks[k])
            leader_chk(i_masks[k]);
        for (int i = 0; i < 12; i++)
        begin
            md = {1'(i), 2'(i % 3), 2'(i % 4), 2'(3 - i % 4), 1'($urandom)};
            eq = 8'($urandom);
            eq = eq | ((eq >> 1) & 8'h55);
            bd = (i == 0) ? 8'h08 : (i == 11) ? 8'h64 : 8'(8 + $urandom_range(92));
            wr(8'h10, md);
            wr(8'h11, eq);
            wr(8'h12, bd);
            cfg_chk();
            foreach (shadow[k])
                rd_chk(8'(8'h10 + k));
            leader_chk(8'h00);
            leader_chk(8'h01 << $urandom_range(7));
        end
        // Reset in mid-run must bring every field back to its reset value
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        shadow = '{8'h3e, 8'h00, 8'h00};
        cfg_chk();
        foreach (shadow[k])
            rd_chk(8'(8'h10 + k));
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end
endmodule // test_dsi_receiver_config_regs
